// ---- pkg/fdic_regs.svh ----
// register offsets, field positions and timing figures of the fan drive input control
`ifndef FDIC_REGS_SVH
`define FDIC_REGS_SVH

// register byte offsets
`define FDIC_CTRL_OFS      8'h00
`define FDIC_STATUS_OFS    8'h04
`define FDIC_IRQ_STAT_OFS  8'h08
`define FDIC_IRQ_MASK_OFS  8'h0c

// control fields and reset values
`define FDIC_CTRL_RUN_BIT  0
`define FDIC_CTRL_RESET    1'b1

// interrupt event bit positions
`define FDIC_EV_OVERCUR    0
`define FDIC_EV_LOCK       1
`define FDIC_EV_STANDBY    2
`define FDIC_EV_RUNNING    3
`define FDIC_EV_NUM        4

// startup interval strap codes
`define FDIC_SEL_GND       2'h0
`define FDIC_SEL_SUPPLY    2'h1

// edges after reset before the strap synchroniser holds pin values
`define FDIC_SYNC_FILL     2'h2

// clock and timing figures in their own units
`define FDIC_CLK_MHZ       200
`define FDIC_MIN_PULSE_NS  6000
`define FDIC_OC_BLANK_US   25
`define FDIC_STANDBY_US    500
`define FDIC_LOCK_ON_MS    2000
`define FDIC_LOCK_OFF_MS   5000
`define FDIC_START_GND_MS  100
`define FDIC_START_SUP_MS  50
`define FDIC_START_OPEN_MS 200
`define FDIC_ZC_TO_RUN     96

// derived cycle counts; least times round up
`define FDIC_MIN_PULSE_CYC ((`FDIC_MIN_PULSE_NS * `FDIC_CLK_MHZ + 999) / 1000)
`define FDIC_OC_BLANK_CYC  (`FDIC_OC_BLANK_US * `FDIC_CLK_MHZ)
`define FDIC_STANDBY_CYC   (`FDIC_STANDBY_US * `FDIC_CLK_MHZ)
`define FDIC_MS_CYC(ms)    ((ms) * `FDIC_CLK_MHZ * 1000)

`endif

// ---- pkg/fdic_pkg.sv ----
// types of the fan drive input control
package fdic_pkg;

   // gray coded along standby -> start -> run -> lockout
   typedef enum logic [1:0] {
      FDIC_STANDBY = 2'h0,
      FDIC_START   = 2'h1,
      FDIC_RUN     = 2'h3,
      FDIC_LOCKOUT = 2'h2
   } fdic_state_t;

   typedef struct packed {
      logic        spdMeta;
      logic        spdSync;
      logic        spdDly;
      logic        ocMeta;
      logic        ocSync;
      logic        zcMeta;
      logic        zcSync;
      logic        zcDly;
      logic [2:0]  strapMeta;
      logic [2:0]  strapSync;
      logic        strapTaken;
      logic [1:0]  strapWait;
      logic        softEn;
      logic [31:0] interval;
      fdic_state_t state;
      logic [15:0] minCnt;
      logic [31:0] lowCnt;
      logic [15:0] ocCnt;
      logic [31:0] lockCnt;
      logic [31:0] stepCnt;
      logic [6:0]  zcCnt;
      logic        drive;
      logic        step;
      logic        stby;
      logic        runEn;
      logic [3:0]  irqStat;
      logic [3:0]  irqMask;
      logic        irq;
      logic [31:0] rdata;
   } fdic_regs_t;

endpackage

// ---- verilog/fdic_top.sv ----
// input control of a sensorless three-phase fan driver
`timescale 1ns/100ps
`include "fdic_regs.svh"

// Function
// R1: the winding drive follows the speed input so that its duty sets the average drive duty.
// R2: an unconnected speed input reads as high and gives full drive.
// R3: holding the speed input low stops the motor and releasing it starts it again.
// R4: speed input waveforms of 15 to 30 kHz pass to the drive without re-timing.
// R5: very short input pulses are stretched to a drive pulse of at least 6 us.
// R6: soft switching is on when its select strap is grounded and off when open.
// R7: the forced startup interval is 100 ms grounded, 50 ms on supply and 200 ms open.
// R8: an overcurrent trip turns all drivers off for 25 us.
// R9: the integrator should pick 50 ms and go longer only if startup back-EMF is poor.
// R10: during startup the drive is full on until 96 zero crossings are counted.
// R11: a speed input held low for 500 us puts the device in standby.
// R12: with no zero crossing for 2 s the outputs are off for 5 s, then restart.
// R13: startup commutation steps come from an internal timer until zero crossings take over.
// R14: the speed input passes a two-stage synchroniser before any use.
module fdic_top
   import fdic_pkg::*;
#(
   parameter int unsigned MIN_PULSE_CYC  = `FDIC_MIN_PULSE_CYC,
   parameter int unsigned OC_BLANK_CYC   = `FDIC_OC_BLANK_CYC,
   parameter int unsigned STANDBY_CYC    = `FDIC_STANDBY_CYC,
   parameter int unsigned LOCK_ON_CYC    = `FDIC_MS_CYC(`FDIC_LOCK_ON_MS),
   parameter int unsigned LOCK_OFF_CYC   = `FDIC_MS_CYC(`FDIC_LOCK_OFF_MS),
   parameter int unsigned START_GND_CYC  = `FDIC_MS_CYC(`FDIC_START_GND_MS),
   parameter int unsigned START_SUP_CYC  = `FDIC_MS_CYC(`FDIC_START_SUP_MS),
   parameter int unsigned START_OPEN_CYC = `FDIC_MS_CYC(`FDIC_START_OPEN_MS),
   parameter int unsigned ZC_TO_RUN      = `FDIC_ZC_TO_RUN
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        srst,
   // pins
   input  wire logic        speedIn,
   input  wire logic        softSwitchSelect,
   input  wire logic [1:0]  startupIntervalSelect,
   input  wire logic        overcurrentTrip,
   input  wire logic        zeroCrossFlag,
   // register port
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [31:0] regRdata,
   // drive side
   output logic             driveOn,
   output logic             commStep,
   output logic             softSwitchEn,
   output logic             standby,
   output logic             irq
);

   fdic_regs_t r_reg;
   fdic_regs_t r_next;

   logic       spdRise;
   logic       zcPulse;
   logic       blanked;
   logic [3:0] events;
   logic [3:0] w1c;

   always_comb begin
      r_next = r_reg;
      events = 4'h0;
      w1c    = 4'h0;
      // synchronisers; first stage is read only by the second
      r_next.spdMeta   = speedIn;                                  // R14
      r_next.spdSync   = r_reg.spdMeta;                            // R14
      r_next.spdDly    = r_reg.spdSync;
      r_next.ocMeta    = overcurrentTrip;
      r_next.ocSync    = r_reg.ocMeta;
      r_next.zcMeta    = zeroCrossFlag;
      r_next.zcSync    = r_reg.zcMeta;
      r_next.zcDly     = r_reg.zcSync;
      r_next.strapMeta = {softSwitchSelect, startupIntervalSelect};
      r_next.strapSync = r_reg.strapMeta;
      spdRise = r_reg.spdSync && !r_reg.spdDly;
      zcPulse = r_reg.zcSync && !r_reg.zcDly;

      // straps are caught once, after the synchroniser has filled;
      // its stages are reset too, so reading them earlier would catch the reset value
      if (!r_reg.strapTaken) begin
         if (r_reg.strapWait == `FDIC_SYNC_FILL) begin
            r_next.strapTaken = 1'b1;
            r_next.softEn     = !r_reg.strapSync[2];               // R6
            case (r_reg.strapSync[1:0])                            // R7
               `FDIC_SEL_GND:    r_next.interval = 32'(START_GND_CYC);
               `FDIC_SEL_SUPPLY: r_next.interval = 32'(START_SUP_CYC);
               default:          r_next.interval = 32'(START_OPEN_CYC);
            endcase
         end else begin
            r_next.strapWait = r_reg.strapWait + 2'h1;
         end
      end

      // overcurrent blanking restarts while the trip persists
      if (r_reg.ocSync) begin
         r_next.ocCnt = 16'(OC_BLANK_CYC);                         // R8
         if (r_reg.ocCnt == 16'h0000)
            events[`FDIC_EV_OVERCUR] = 1'b1;
      end else if (r_reg.ocCnt != 16'h0000) begin
         r_next.ocCnt = r_reg.ocCnt - 16'h0001;
      end
      blanked = r_reg.ocSync || r_reg.ocCnt != 16'h0000;

      // minimum on-pulse stretcher
      if (spdRise)
         r_next.minCnt = 16'(MIN_PULSE_CYC - 1);                   // R5
      else if (r_reg.minCnt != 16'h0000)
         r_next.minCnt = r_reg.minCnt - 16'h0001;

      // low time toward standby
      if (r_reg.spdSync)
         r_next.lowCnt = 32'h0;
      else if (r_reg.lowCnt != 32'(STANDBY_CYC))
         r_next.lowCnt = r_reg.lowCnt + 32'h1;                     // R11

      r_next.step = 1'b0;
      case (r_reg.state)
         FDIC_STANDBY: begin
            if (r_reg.spdSync && r_reg.runEn && r_reg.strapTaken) begin
               r_next.state   = FDIC_START;                        // R3
               r_next.stepCnt = 32'h0;
               r_next.zcCnt   = 7'h00;
               r_next.lockCnt = 32'h0;
            end
         end
         FDIC_START, FDIC_RUN: begin
            if (r_reg.state == FDIC_START) begin
               if (r_reg.stepCnt >= r_reg.interval - 32'h1) begin
                  r_next.stepCnt = 32'h0;
                  r_next.step    = 1'b1;                           // R13
               end else begin
                  r_next.stepCnt = r_reg.stepCnt + 32'h1;
               end
               if (zcPulse) begin
                  r_next.zcCnt = r_reg.zcCnt + 7'h01;
                  if (r_reg.zcCnt == 7'(ZC_TO_RUN - 1)) begin
                     r_next.state = FDIC_RUN;                      // R10
                     events[`FDIC_EV_RUNNING] = 1'b1;
                  end
               end
            end
            if (zcPulse) begin
               r_next.lockCnt = 32'h0;
            end else if (r_reg.lockCnt >= 32'(LOCK_ON_CYC - 1)) begin
               r_next.state   = FDIC_LOCKOUT;                      // R12
               r_next.lockCnt = 32'h0;
               events[`FDIC_EV_LOCK] = 1'b1;
            end else begin
               r_next.lockCnt = r_reg.lockCnt + 32'h1;
            end
            if (r_reg.lowCnt == 32'(STANDBY_CYC) || !r_reg.runEn) begin
               r_next.state = FDIC_STANDBY;                        // R11
               events[`FDIC_EV_STANDBY] = 1'b1;
            end
         end
         FDIC_LOCKOUT: begin
            if (r_reg.lockCnt >= 32'(LOCK_OFF_CYC - 1)) begin
               r_next.state   = FDIC_START;                        // R12
               r_next.lockCnt = 32'h0;
               r_next.stepCnt = 32'h0;
               r_next.zcCnt   = 7'h00;
            end else begin
               r_next.lockCnt = r_reg.lockCnt + 32'h1;
            end
            if (r_reg.lowCnt == 32'(STANDBY_CYC) || !r_reg.runEn) begin
               r_next.state = FDIC_STANDBY;
               events[`FDIC_EV_STANDBY] = 1'b1;
            end
         end
         default: r_next.state = FDIC_STANDBY;
      endcase

      // drive: input duty passes straight through, stretched, forced full at startup
      case (r_reg.state)
         FDIC_START: r_next.drive = !blanked;                      // R10 R8
         FDIC_RUN:   r_next.drive = !blanked &&
                                    (r_reg.spdSync || r_reg.minCnt != 16'h0000); // R1 R4 R5 R8
         default:    r_next.drive = 1'b0;
      endcase
      r_next.stby = r_next.state == FDIC_STANDBY;

      // register writes; a set in the same cycle beats the clear
      if (regWr) begin
         case (regAddr)
            `FDIC_CTRL_OFS:     r_next.runEn   = regWdata[`FDIC_CTRL_RUN_BIT];
            `FDIC_IRQ_STAT_OFS: w1c            = regWdata[3:0];
            `FDIC_IRQ_MASK_OFS: r_next.irqMask = regWdata[3:0];
            default:            r_next.runEn   = r_reg.runEn;
         endcase
      end
      r_next.irqStat = (r_reg.irqStat & ~w1c) | events;
      r_next.irq     = |(r_next.irqStat & r_next.irqMask);

      // read data stands only in the cycle after the strobe
      r_next.rdata = 32'h0;
      if (regRd) begin
         case (regAddr)
            `FDIC_CTRL_OFS:     r_next.rdata = {31'h0, r_reg.runEn};
            `FDIC_STATUS_OFS:   r_next.rdata = {17'h0, r_reg.zcCnt, r_reg.softEn,
                                                r_reg.spdSync, r_reg.drive, blanked,
                                                r_reg.strapSync[1:0], r_reg.state};
            `FDIC_IRQ_STAT_OFS: r_next.rdata = {28'h0, r_reg.irqStat};
            `FDIC_IRQ_MASK_OFS: r_next.rdata = {28'h0, r_reg.irqMask};
            default:            r_next.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         r_reg            <= '0;
         // pulled-up pins idle high so an open input reads as full drive
         r_reg.spdMeta    <= 1'b1;                                 // R2
         r_reg.spdSync    <= 1'b1;                                 // R2
         r_reg.spdDly     <= 1'b1;
         r_reg.strapMeta  <= 3'h7;
         r_reg.strapSync  <= 3'h7;
         r_reg.interval   <= 32'(START_OPEN_CYC);
         r_reg.state      <= FDIC_STANDBY;
         r_reg.stby       <= 1'b1;
         r_reg.runEn      <= `FDIC_CTRL_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   assign regRdata     = r_reg.rdata;
   assign driveOn      = r_reg.drive;
   assign commStep     = r_reg.step;
   assign softSwitchEn = r_reg.softEn;
   assign standby      = r_reg.stby;
   assign irq          = r_reg.irq;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   sequence trip_seen_s;
      r_reg.ocSync;
   endsequence
   sequence drive_off_s;
      !driveOn [*2];
   endsequence

   oc_blank_off_a: assert property (trip_seen_s |=> drive_off_s) // R8
      else $error("drive not off after overcurrent trip");

   oc_blank_len_a: assert property ($fell(r_reg.ocSync) |-> r_reg.ocCnt == 16'(OC_BLANK_CYC)) // R8
      else $error("overcurrent blank count not loaded");

   min_pulse_a: assert property ( // R5
      r_reg.state == FDIC_RUN && spdRise && !blanked ##1 r_reg.state == FDIC_RUN && !blanked
      |-> driveOn && r_reg.minCnt == 16'(MIN_PULSE_CYC - 1))
      else $error("drive pulse not stretched");

   pass_through_a: assert property ( // R1
      r_reg.state == FDIC_RUN && !blanked && r_reg.minCnt == 16'h0000 |=>
      driveOn == $past(r_reg.spdSync))
      else $error("drive does not follow speed input");

   startup_full_a: assert property (r_reg.state == FDIC_START && !blanked |=> driveOn) // R10
      else $error("startup drive not full");

   run_after_count_a: assert property ( // R10
      $rose(r_reg.state == FDIC_RUN) |-> $past(r_reg.zcCnt) == 7'(ZC_TO_RUN - 1))
      else $error("run entered at wrong crossing count");

   standby_entry_a: assert property ( // R11
      r_reg.state != FDIC_STANDBY && r_reg.lowCnt == 32'(STANDBY_CYC) |=> standby ##1 !driveOn)
      else $error("standby not entered after low time");

   sync_order_a: assert property ($changed(r_reg.spdSync) |-> r_reg.spdSync == $past(speedIn, 2)) // R14
      else $error("speed input bypassed synchroniser");

   lock_off_a: assert property ($rose(r_reg.state == FDIC_LOCKOUT) |-> ##1 !driveOn) // R12
      else $error("outputs not off in lockout");

   step_start_a: assert property (commStep |-> $past(r_reg.state) == FDIC_START) // R13
      else $error("forced step outside startup");

   soft_strap_a: assert property ($rose(r_reg.strapTaken) |-> softSwitchEn == !$past(r_reg.strapSync[2])) // R6
      else $error("soft switch strap misread");

   restart_a: assert property (r_reg.state == FDIC_STANDBY && r_reg.spdSync && r_reg.runEn && r_reg.strapTaken
      |=> r_reg.state == FDIC_START) // R3
      else $error("no restart on speed input high");

   // strap capture
   strap_gnd_a: assert property ( // R7
      $rose(r_reg.strapTaken) && $past(r_reg.strapSync[1:0]) == `FDIC_SEL_GND
      |-> r_reg.interval == 32'(START_GND_CYC))
      else $error("ground strap interval wrong");

   strap_sup_a: assert property ( // R7
      $rose(r_reg.strapTaken) && $past(r_reg.strapSync[1:0]) == `FDIC_SEL_SUPPLY
      |-> r_reg.interval == 32'(START_SUP_CYC))
      else $error("supply strap interval wrong");

   strap_open_a: assert property ( // R7
      $rose(r_reg.strapTaken) && $past(r_reg.strapSync[1])
      |-> r_reg.interval == 32'(START_OPEN_CYC))
      else $error("open strap interval wrong");

   strap_hold_a: assert property (r_reg.strapTaken |=> r_reg.strapTaken && $stable(softSwitchEn)) // R6
      else $error("strap selection changed after capture");

   // protection
   oc_event_a: assert property (r_reg.ocSync && r_reg.ocCnt == 16'h0000 |=> r_reg.irqStat[`FDIC_EV_OVERCUR]) // R8
      else $error("overcurrent event not recorded");

   oc_hold_a: assert property (r_reg.ocCnt != 16'h0000 |=> !driveOn) // R8
      else $error("drive on during overcurrent blank");

   lock_event_a: assert property ($rose(r_reg.state == FDIC_LOCKOUT) |-> r_reg.irqStat[`FDIC_EV_LOCK]) // R12
      else $error("lock event not recorded");

   sequence lock_done_s;
      r_reg.state == FDIC_LOCKOUT && r_reg.lockCnt >= 32'(LOCK_OFF_CYC - 1);
   endsequence
   sequence stays_up_s;
      r_reg.lowCnt != 32'(STANDBY_CYC) && r_reg.runEn;
   endsequence

   lock_restart_a: assert property (lock_done_s ##0 stays_up_s |=> r_reg.state == FDIC_START) // R12
      else $error("no restart after lock off time");

   // run and stop
   run_stop_a: assert property (!r_reg.runEn && r_reg.state != FDIC_STANDBY |=> standby) // R3
      else $error("run disable did not stop the drive");

   standby_drive_a: assert property (standby |=> !driveOn) // R11
      else $error("drive on in standby");

   zc_count_a: assert property ( // R10
      r_reg.state == FDIC_START && zcPulse |=> r_reg.zcCnt == $past(r_reg.zcCnt) + 7'h01)
      else $error("zero crossing not counted");

   step_pace_a: assert property ( // R13
      r_reg.state == FDIC_START && r_reg.stepCnt >= r_reg.interval - 32'h1 |=> commStep)
      else $error("forced step missing at interval end");

endmodule // fdic_top

// ---- sim/fdic_fan_model.sv ----
// far side model: host speed pwm source and the spinning fan windings
`timescale 1ns/100ps
module fdic_fan_model (
   // clock
   input  wire logic       sys_clk,
   // host speed command
   input  wire logic [7:0] pwmPeriod,
   input  wire logic [7:0] pwmHigh,
   // motor
   input  wire logic       spin,
   output logic            speedIn,
   output logic            zeroCrossFlag
);
   logic [7:0] pwmCnt = 8'h00;
   logic [3:0] zcCnt  = 4'h0;

   // host pwm runs free at a fixed period; the duty alone carries the speed
   always_ff @(posedge sys_clk) begin
      pwmCnt <= (pwmCnt + 8'h01 >= pwmPeriod) ? 8'h00 : pwmCnt + 8'h01;
      zcCnt  <= spin ? zcCnt + 4'h1 : 4'h0;
   end
   // duty 0 holds the pin low to stop, full duty releases it
   assign speedIn = pwmCnt < pwmHigh;
   // a stalled rotor gives no back-emf crossings at all
   assign zeroCrossFlag = spin & zcCnt[3];
endmodule // fdic_fan_model

// ---- sim/fdic_top_tb_top.sv ----
// self-checking bench of the fan drive input control
`timescale 1ns/100ps
`include "fdic_regs.svh"
module fdic_top_tb_top;
   logic        sys_clk               = 1'b0;
   logic        srst;
   logic        softSwitchSelect;
   logic [1:0]  startupIntervalSelect;
   logic        overcurrentTrip;
   logic [7:0]  regAddr;
   logic [31:0] regWdata;
   logic        regWr;
   logic        regRd;
   logic [7:0]  pwmPeriod;
   logic [7:0]  pwmHigh;
   logic        spin;
   logic [31:0] regRdata;
   logic        speedIn;
   logic        zeroCrossFlag;
   logic        driveOn;
   logic        commStep;
   logic        softSwitchEn;
   logic        standby;
   logic        irq;
   logic [31:0] rv;
   int          mismatches            = 0;
   int          check_count           = 0;

   always #2.5 sys_clk = ~sys_clk;

   // counts shortened so the whole run stays short
   fdic_top #(.MIN_PULSE_CYC(8), .OC_BLANK_CYC(20), .STANDBY_CYC(50), .LOCK_ON_CYC(400),
      .LOCK_OFF_CYC(200), .START_GND_CYC(20), .START_SUP_CYC(10), .START_OPEN_CYC(40),
      .ZC_TO_RUN(4)) fdic_top_i (
      .sys_clk(sys_clk), .srst(srst), .speedIn(speedIn), .softSwitchSelect(softSwitchSelect),
      .startupIntervalSelect(startupIntervalSelect), .overcurrentTrip(overcurrentTrip),
      .zeroCrossFlag(zeroCrossFlag), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .driveOn(driveOn), .commStep(commStep), .softSwitchEn(softSwitchEn),
      .standby(standby), .irq(irq));
   fdic_fan_model fdic_fan_model_i (.sys_clk(sys_clk), .pwmPeriod(pwmPeriod), .pwmHigh(pwmHigh), .spin(spin),
      .speedIn(speedIn), .zeroCrossFlag(zeroCrossFlag));

   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   function automatic logic sig(int k);
      return k == 0 ? driveOn : k == 1 ? commStep : standby;
   endfunction

   // bounded wait; a missing event shows up as a count at the limit
   task automatic upto(int k, logic v, int lim, output int n);
      n = 0;
      while (sig(k) !== v && n < lim) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
   endtask

   task automatic hicount(int len, output int h);
      h = 0;
      repeat (len) begin
         @(posedge sys_clk);
         #1;
         h += int'(driveOn === 1'b1);
      end
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge sys_clk);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask

   task automatic rd(logic [7:0] a);
      @(posedge sys_clk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1;
      rv = regRdata;
   endtask

   task automatic setpwm(logic [7:0] p, logic [7:0] h, logic sp);
      @(posedge sys_clk);
      pwmPeriod <= p;
      pwmHigh   <= h;
      spin      <= sp;
      #1;
   endtask

   task automatic do_reset(logic ss, logic [1:0] sel);
      setpwm(8'h01, 8'h00, 1'b0);
      @(posedge sys_clk);
      softSwitchSelect      <= ss;
      startupIntervalSelect <= sel;
      srst                  <= 1'b1;
      repeat (4) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (6) @(posedge sys_clk);
      #1;
   endtask

   task automatic t_straps();
      int n;
      int h;
      int iv[4] = '{20, 10, 40, 40};
      for (int s = 0; s < 4; s++) begin
         do_reset(s[0], s[1:0]);
         chk("standby", standby, 1'b1);
         chk("softEn", softSwitchEn, !s[0]);
         rd(`FDIC_STATUS_OFS);
         chk("strap", rv[3:2], s[1:0]);
         setpwm(8'h28, 8'h14, 1'b0);
         upto(1, 1'b1, 100, n);
         @(posedge sys_clk);
         #1;
         upto(1, 1'b1, 100, n);
         chk("interval", n + 1, iv[s]);
         // startup ignores the pwm low half
         hicount(40, h);
         chk("fullDrive", h, 40);
      end
   endtask

   task automatic t_run();
      int n;
      int h;
      do_reset(1'b1, 2'h1);
      rd(`FDIC_CTRL_OFS);
      chk("ctrl", rv, 32'h1);
      rd(8'h10);
      chk("unmapped", rv, 32'h0);
      wr(`FDIC_IRQ_MASK_OFS, 32'hf);
      rd(`FDIC_IRQ_MASK_OFS);
      chk("mask", rv, 32'hf);
      setpwm(8'h01, 8'h01, 1'b1);
      repeat (120) @(posedge sys_clk);
      rd(`FDIC_STATUS_OFS);
      chk("run", rv[1:0], 2'h3);
      rd(`FDIC_IRQ_STAT_OFS);
      chk("runEv", rv[3], 1'b1);
      chk("irq", irq, 1'b1);
      wr(`FDIC_IRQ_STAT_OFS, 32'hf);
      rd(`FDIC_IRQ_STAT_OFS);
      chk("w1c", rv, 32'h0);
      chk("irqClr", irq, 1'b0);
      setpwm(8'h28, 8'h14, 1'b1);
      repeat (80) @(posedge sys_clk);
      hicount(400, h);
      chk("duty", h, 200);
      setpwm(8'h28, 8'h01, 1'b1);
      repeat (80) @(posedge sys_clk);
      // start from a low phase so a whole stretched pulse is measured
      upto(0, 1'b0, 50, n);
      upto(0, 1'b1, 50, n);
      upto(0, 1'b0, 50, n);
      chk("minPulse", n >= 7 && n <= 9, 1'b1);
   endtask

   task automatic t_prot();
      int n;
      setpwm(8'h01, 8'h01, 1'b1);
      repeat (10) @(posedge sys_clk);
      overcurrentTrip <= 1'b1;
      @(posedge sys_clk);
      overcurrentTrip <= 1'b0;
      #1;
      upto(0, 1'b0, 6, n);
      upto(0, 1'b1, 60, n);
      chk("blank", n >= 20 && n <= 24, 1'b1);
      rd(`FDIC_IRQ_STAT_OFS);
      chk("ocEv", rv[0], 1'b1);
      setpwm(8'h01, 8'h00, 1'b1);
      upto(2, 1'b1, 70, n);
      chk("stbyTime", n >= 50 && n <= 60, 1'b1);
      chk("stbyOff", driveOn, 1'b0);
      // constant high stands for a floating pin
      setpwm(8'h01, 8'h01, 1'b0);
      upto(2, 1'b0, 10, n);
      repeat (5) @(posedge sys_clk);
      #1;
      chk("openFull", driveOn, 1'b1);
      wr(`FDIC_CTRL_OFS, 32'h0);
      repeat (3) @(posedge sys_clk);
      #1;
      chk("runEnOff", standby, 1'b1);
      wr(`FDIC_CTRL_OFS, 32'h1);
      upto(0, 1'b1, 20, n);
      upto(0, 1'b0, 500, n);
      chk("lockOn", n >= 395 && n <= 410, 1'b1);
      rd(`FDIC_STATUS_OFS);
      chk("lockout", rv[1:0], 2'h2);
      upto(0, 1'b1, 300, n);
      chk("lockOff", n >= 195 && n <= 210, 1'b1);
      rd(`FDIC_IRQ_STAT_OFS);
      chk("lockEv", rv[1], 1'b1);
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // the run needs well under 20000 cycles
   initial begin
      #100000;
      mismatches++;
      end_sim();
   end

   initial begin
      srst                  <= 1'b1;
      softSwitchSelect      <= 1'b0;
      startupIntervalSelect <= 2'h1;
      overcurrentTrip       <= 1'b0;
      regAddr               <= 8'h00;
      regWdata              <= 32'h0;
      regWr                 <= 1'b0;
      regRd                 <= 1'b0;
      pwmPeriod             <= 8'h01;
      pwmHigh               <= 8'h00;
      spin                  <= 1'b0;
      t_straps();
      t_run();
      t_prot();
      end_sim();
   end
endmodule // fdic_top_tb_top
